// file: shared/hsk_pkg.sv
package hsk_pkg;

	// ----------------------------------------------------------------
	// Widths and memory size
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int ID_W = 4;
	localparam int LEN_W = 8;
	localparam int RESP_W = 2;
	localparam int MEM_AW = 4;
	localparam int MEM_DEPTH = 16;
	localparam int WORD_LSB = 2;

	// ----------------------------------------------------------------
	// Response codes
	// ----------------------------------------------------------------
	localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;

	// ----------------------------------------------------------------
	// State encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		WR_IDLE = 3'h1,
		WR_DATA = 3'h2,
		WR_RESP = 3'h4
	} hsk_wr_state_type;

	typedef enum logic [1:0]
	{
		RD_IDLE = 2'h1,
		RD_DATA = 2'h2
	} hsk_rd_state_type;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [ID_W-1:0] id;
		logic [RESP_W-1:0] resp;
	} hsk_bresp_type;

	typedef struct packed
	{
		logic [ID_W-1:0] id;
		logic [DATA_W-1:0] data;
		logic [RESP_W-1:0] resp;
		logic last;
	} hsk_rbeat_type;

	typedef struct packed
	{
		hsk_wr_state_type wr_state;
		logic aw_ready;
		logic w_ready;
		logic b_valid;
		hsk_bresp_type b;
		logic [MEM_AW-1:0] w_idx;
		logic [ID_W-1:0] w_id;
		hsk_rd_state_type rd_state;
		logic ar_ready;
		logic r_valid;
		hsk_rbeat_type r;
		logic [MEM_AW-1:0] r_idx;
		logic [LEN_W-1:0] r_beat;
		logic [LEN_W-1:0] r_len;
		logic [MEM_DEPTH-1:0][DATA_W-1:0] mem;
	} hsk_state_type;

	// Both address readies idle high; every valid idles low.
	localparam hsk_state_type ST_RESET = '{
		wr_state: WR_IDLE,
		aw_ready: 1'b1,
		rd_state: RD_IDLE,
		ar_ready: 1'b1,
		default: '0
	};

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Word index of a byte address inside the local memory.
	function automatic logic [MEM_AW-1:0] hsk_word_index(input logic [ADDR_W-1:0] a);
		return a[WORD_LSB +: MEM_AW];
	endfunction

endpackage

// file: src/hsk_slave.sv
`timescale 1ns/1ps
module hsk_slave
	import hsk_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic AWVALID,
	input wire logic [ID_W-1:0] AWID,
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic [LEN_W-1:0] AWLEN,
	output logic AWREADY,
	input wire logic WVALID,
	input wire logic [DATA_W-1:0] WDATA,
	input wire logic WLAST,
	output logic WREADY,
	output logic BVALID,
	output logic [ID_W-1:0] BID,
	output logic [RESP_W-1:0] BRESP,
	input wire logic BREADY,
	input wire logic ARVALID,
	input wire logic [ID_W-1:0] ARID,
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic [LEN_W-1:0] ARLEN,
	output logic ARREADY,
	output logic RVALID,
	output logic [ID_W-1:0] RID,
	output logic [DATA_W-1:0] RDATA,
	output logic [RESP_W-1:0] RRESP,
	output logic RLAST,
	input wire logic RREADY
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	hsk_state_type st_q;
	hsk_state_type st_d;

	logic aw_fire;
	logic w_fire;
	logic b_fire;
	logic ar_fire;
	logic r_fire;

	// Handshakes complete only when both sides are high at the edge.
	assign aw_fire = AWVALID && st_q.aw_ready;
	assign w_fire = WVALID && st_q.w_ready;
	assign b_fire = st_q.b_valid && BREADY;
	assign ar_fire = ARVALID && st_q.ar_ready;
	assign r_fire = st_q.r_valid && RREADY;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Write path: address, then data beats, then one response.
	// Read path: address, then a burst of beats ending with the last flag.
	always_comb
	begin
		st_d = st_q;
		case (st_q.wr_state)
			WR_IDLE:
			begin
				// Write data offered early simply waits; the address side is open.
				if (aw_fire)
				begin
					st_d.w_idx = hsk_word_index(AWADDR);
					st_d.w_id = AWID;
					st_d.aw_ready = 1'b0;
					st_d.w_ready = 1'b1;
					st_d.wr_state = WR_DATA;
				end
			end
			WR_DATA:
			begin
				if (w_fire)
				begin
					st_d.mem[st_q.w_idx] = WDATA;
					st_d.w_idx = MEM_AW'(st_q.w_idx + 1'b1);
					if (WLAST)
					begin
						st_d.w_ready = 1'b0;
						st_d.b_valid = 1'b1;
						st_d.b.id = st_q.w_id;
						st_d.b.resp = RESP_OKAY;
						st_d.wr_state = WR_RESP;
					end
				end
			end
			WR_RESP:
			begin
				// The response stays up, unchanged, until the master takes it.
				if (b_fire)
				begin
					st_d.b_valid = 1'b0;
					st_d.aw_ready = 1'b1;
					st_d.wr_state = WR_IDLE;
				end
			end
			default:
			begin
				st_d.wr_state = WR_IDLE;
				st_d.aw_ready = 1'b1;
				st_d.w_ready = 1'b0;
				st_d.b_valid = 1'b0;
			end
		endcase
		case (st_q.rd_state)
			RD_IDLE:
			begin
				// Read data is offered only after an address was accepted.
				if (ar_fire)
				begin
					st_d.ar_ready = 1'b0;
					st_d.r_valid = 1'b1;
					st_d.r_idx = MEM_AW'(hsk_word_index(ARADDR) + 1'b1);
					st_d.r_beat = '0;
					st_d.r_len = ARLEN;
					st_d.r.id = ARID;
					st_d.r.data = st_q.mem[hsk_word_index(ARADDR)];
					st_d.r.resp = RESP_OKAY;
					st_d.r.last = (ARLEN == '0);
					st_d.rd_state = RD_DATA;
				end
			end
			RD_DATA:
			begin
				// A beat stays on the pins until the master takes it.
				if (r_fire)
				begin
					if (st_q.r.last)
					begin
						st_d.r_valid = 1'b0;
						st_d.r.last = 1'b0;
						st_d.ar_ready = 1'b1;
						st_d.rd_state = RD_IDLE;
					end
					else
					begin
						st_d.r_beat = LEN_W'(st_q.r_beat + 1'b1);
						st_d.r_idx = MEM_AW'(st_q.r_idx + 1'b1);
						st_d.r.data = st_q.mem[st_q.r_idx];
						st_d.r.last = (LEN_W'(st_q.r_beat + 1'b1) == st_q.r_len);
					end
				end
			end
			default:
			begin
				st_d.rd_state = RD_IDLE;
				st_d.ar_ready = 1'b1;
				st_d.r_valid = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// All state changes on the rising edge; reset clears both valids.
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			st_q <= ST_RESET;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// Every output is a flip-flop, so no input path reaches the pins.
	assign AWREADY = st_q.aw_ready;
	assign WREADY = st_q.w_ready;
	assign BVALID = st_q.b_valid;
	assign BID = st_q.b.id;
	assign BRESP = st_q.b.resp;
	assign ARREADY = st_q.ar_ready;
	assign RVALID = st_q.r_valid;
	assign RID = st_q.r.id;
	assign RDATA = st_q.r.data;
	assign RRESP = st_q.r.resp;
	assign RLAST = st_q.r.last;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Helper copies of beat count, read length and write id, taken from the pins.
	logic [LEN_W-1:0] chk_beats_q;
	logic [LEN_W-1:0] chk_len_q;
	logic [ID_W-1:0] chk_wid_q;

	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			chk_beats_q <= '0;
			chk_len_q <= '0;
			chk_wid_q <= '0;
		end
		else
		begin
			if (ARVALID && ARREADY)
			begin
				chk_beats_q <= '0;
				chk_len_q <= ARLEN;
			end
			else if (RVALID && RREADY)
			begin
				chk_beats_q <= LEN_W'(chk_beats_q + 1'b1);
			end
			if (AWVALID && AWREADY)
			begin
				chk_wid_q <= AWID;
			end
		end
	end

	sequence seq_b_wait;
		BVALID && !BREADY;
	endsequence

	sequence seq_r_wait;
		RVALID && !RREADY;
	endsequence

	sequence seq_ar_taken;
		ARVALID && ARREADY;
	endsequence

	sequence seq_w_final;
		WVALID && WREADY && WLAST;
	endsequence

	sequence seq_aw_taken;
		AWVALID && AWREADY;
	endsequence

	sequence seq_r_final;
		RVALID && RREADY && RLAST;
	endsequence

	a_bvalid_hold: assert property (@(posedge REF_CLK) disable iff (RST)
		seq_b_wait |=> BVALID && $stable(BID) && $stable(BRESP))
	else $error("Response valid dropped or changed before handshake.");

	a_rvalid_hold: assert property (@(posedge REF_CLK) disable iff (RST)
		seq_r_wait |=> RVALID && $stable(RDATA) && $stable(RLAST) && $stable(RID))
	else $error("Read beat dropped or changed before handshake.");

	a_rvalid_cause: assert property (@(posedge REF_CLK) disable iff (RST)
		$rose(RVALID) |-> $past(ARVALID && ARREADY))
	else $error("Read valid rose without an accepted read address.");

	a_read_answer: assert property (@(posedge REF_CLK) disable iff (RST)
		seq_ar_taken |=> RVALID && !ARREADY && RID == $past(ARID))
	else $error("Read address not answered on the next cycle.");

	a_bresp_cause: assert property (@(posedge REF_CLK) disable iff (RST)
		$rose(BVALID) |-> $past(WVALID && WREADY && WLAST))
	else $error("Response raised without a final write beat.");

	a_bresp_follows: assert property (@(posedge REF_CLK) disable iff (RST)
		seq_w_final |=> BVALID && !WREADY)
	else $error("Final write beat not followed by a response.");

	a_rlast_count: assert property (@(posedge REF_CLK) disable iff (RST)
		seq_r_final |-> chk_beats_q == chk_len_q)
	else $error("Last read flag on the wrong beat.");

	a_single_beat: assert property (@(posedge REF_CLK) disable iff (RST)
		(seq_ar_taken ##0 (ARLEN == '0)) |=> RLAST)
	else $error("Single beat burst lacks last flag.");

	a_addr_return: assert property (@(posedge REF_CLK) disable iff (RST)
		(BVALID && BREADY) |=> AWREADY ##1 (AWREADY || $past(AWVALID)))
	else $error("Write address ready did not return after response.");

	a_reset_quiet: assert property (@(posedge REF_CLK) disable iff (1'b0)
		RST |-> !BVALID && !RVALID)
	else $error("Valid high during reset.");

	a_aw_answer: assert property (@(posedge REF_CLK) disable iff (RST)
		seq_aw_taken |=> !AWREADY && WREADY)
	else $error("Write address taken but write data not opened.");

	a_wready_cause: assert property (@(posedge REF_CLK) disable iff (RST)
		$rose(WREADY) |-> $past(AWVALID && AWREADY))
	else $error("Write ready rose without an accepted write address.");

	a_wready_hold: assert property (@(posedge REF_CLK) disable iff (RST)
		(WREADY && !(WVALID && WLAST)) |=> WREADY)
	else $error("Write ready dropped before the final beat.");

	a_aw_closed: assert property (@(posedge REF_CLK) disable iff (RST)
		WREADY |-> !AWREADY && !BVALID)
	else $error("Write data phase overlaps address or response.");

	a_bid_match: assert property (@(posedge REF_CLK) disable iff (RST)
		$rose(BVALID) |-> BID == chk_wid_q && BRESP == RESP_OKAY)
	else $error("Response id does not match the accepted write.");

	a_resp_close: assert property (@(posedge REF_CLK) disable iff (RST)
		(BVALID && BREADY) |=> !BVALID && !WREADY)
	else $error("Response still valid after its handshake.");

	a_read_return: assert property (@(posedge REF_CLK) disable iff (RST)
		seq_r_final |=> ARREADY && !RVALID)
	else $error("Read channel not released after the last beat.");

	a_read_closed: assert property (@(posedge REF_CLK) disable iff (RST)
		RVALID |-> !ARREADY)
	else $error("Read address open while read data is pending.");

	a_beat_bound: assert property (@(posedge REF_CLK) disable iff (RST)
		RVALID |-> chk_beats_q <= chk_len_q)
	else $error("Read burst ran past its length.");

endmodule

// file: sim/hsk_mst_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Manager model facing the slave
// ----------------------------------------------------------------
module hsk_mst_model
	import hsk_pkg::*;
(
	input wire logic clk,
	output logic awvalid,
	output logic [ID_W-1:0] awid,
	output logic [ADDR_W-1:0] awaddr,
	output logic [LEN_W-1:0] awlen,
	input wire logic awready,
	output logic wvalid,
	output logic [DATA_W-1:0] wdata,
	output logic wlast,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic [ID_W-1:0] bid,
	input wire logic [RESP_W-1:0] bresp,
	output logic bready,
	output logic arvalid,
	output logic [ID_W-1:0] arid,
	output logic [ADDR_W-1:0] araddr,
	output logic [LEN_W-1:0] arlen,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [ID_W-1:0] rid,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [RESP_W-1:0] rresp,
	input wire logic rlast,
	output logic rready
);
	hsk_bresp_type b_got;
	hsk_rbeat_type rq[$];

	// All valids start low and stay low through reset.
	initial
	begin
		{awvalid, wvalid, wlast, bready, arvalid, rready} = '0;
		{awid, awaddr, awlen, wdata, arid, araddr, arlen} = '0;
	end

	// Address and data go out together; each is held until its own handshake edge.
	task automatic wr(input logic [ID_W-1:0] id, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d0, input int n, input int bdly);
		int i;
		int k;
		logic ah;
		logic wh;
		awid = id;
		awaddr = a;
		awlen = LEN_W'(n - 1);
		wdata = d0;
		wlast = (n == 1);
		awvalid = 1'b1;
		wvalid = 1'b1;
		i = 0;
		for (k = 0; k < 64 && (awvalid || wvalid); k++)
		begin
			ah = awvalid && awready;
			wh = wvalid && wready;
			@(posedge clk);
			#1;
			if (ah)
			begin
				awvalid = 1'b0;
				awaddr = ~awaddr;
			end
			if (wh)
			begin
				i++;
				wdata = d0 + DATA_W'(i);
				wlast = (i == n - 1);
				wvalid = (i < n);
			end
		end
		for (k = 0; k < 64 && !bvalid; k++)
		begin
			@(posedge clk);
			#1;
		end
		repeat (bdly)
		begin
			@(posedge clk);
			#1;
		end
		bready = 1'b1;
		b_got = {bid, bresp};
		@(posedge clk);
		#1;
		bready = 1'b0;
	endtask

	// Read request, then collect beats; a slow read ready toggles every cycle.
	task automatic rd(input logic [ID_W-1:0] id, input logic [ADDR_W-1:0] a,
		input int n, input bit slow);
		int k;
		logic h;
		rq = {};
		arid = id;
		araddr = a;
		arlen = LEN_W'(n - 1);
		arvalid = 1'b1;
		h = 1'b0;
		for (k = 0; k < 64 && !h; k++)
		begin
			h = arready;
			@(posedge clk);
			#1;
		end
		arvalid = 1'b0;
		araddr = ~araddr;
		rready = !slow;
		for (k = 0; k < 256 && rq.size() < n; k++)
		begin
			h = rvalid && rready;
			if (h)
				rq.push_back({rid, rdata, rresp, rlast});
			@(posedge clk);
			#1;
			if (rq.size() < n)
				rready = !slow || k[0];
		end
		rready = 1'b0;
	endtask
endmodule

// file: sim/test_hsk_slave.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the handshake slave
// ----------------------------------------------------------------
module test_hsk_slave
	import hsk_pkg::*;
;
	logic ref_clk, rst, awvalid, awready, wvalid, wlast, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rlast, rready;
	logic [ID_W-1:0] awid, bid, arid, rid;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [LEN_W-1:0] awlen, arlen;
	logic [DATA_W-1:0] wdata, rdata;
	logic [RESP_W-1:0] bresp, rresp;
	int err_count = 0;
	int n_tests = 0;

	hsk_mst_model m (.clk(ref_clk), .awvalid, .awid, .awaddr, .awlen, .awready, .wvalid,
		.wdata, .wlast, .wready, .bvalid, .bid, .bresp, .bready, .arvalid, .arid, .araddr,
		.arlen, .arready, .rvalid, .rid, .rdata, .rresp, .rlast, .rready);

	hsk_slave uut (.REF_CLK(ref_clk), .RST(rst), .AWVALID(awvalid), .AWID(awid),
		.AWADDR(awaddr), .AWLEN(awlen), .AWREADY(awready), .WVALID(wvalid), .WDATA(wdata),
		.WLAST(wlast), .WREADY(wready), .BVALID(bvalid), .BID(bid), .BRESP(bresp),
		.BREADY(bready), .ARVALID(arvalid), .ARID(arid), .ARADDR(araddr), .ARLEN(arlen),
		.ARREADY(arready), .RVALID(rvalid), .RID(rid), .RDATA(rdata), .RRESP(rresp),
		.RLAST(rlast), .RREADY(rready));

	// Counts a comparison and reports a mismatch at once.
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task print_verdict;
		if (err_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Idle levels after reset, and no read data without a request.
	task t_reset;
		chk({awready, arready, bvalid, rvalid, wready}, 5'h18);
		repeat (4) @(posedge ref_clk);
		#1;
		chk({bvalid, rvalid}, 2'h0);
	endtask

	// Wrapping three-beat burst with a slow response ready, then a single beat.
	task t_writes;
		m.wr(4'h5, 12'h03c, 32'ha5a5_0000, 3, 3);
		chk(m.b_got, {4'h5, RESP_OKAY});
		m.wr(4'ha, 12'h008, 32'h5a5a_1234, 1, 0);
		chk(m.b_got, {4'ha, RESP_OKAY});
	endtask

	// Four beats read back across the wrap under a stalling read ready.
	task t_read_burst;
		logic [DATA_W-1:0] exp[4];
		int i;
		exp = '{32'ha5a5_0000, 32'ha5a5_0001, 32'ha5a5_0002, 32'h5a5a_1234};
		m.rd(4'h3, 12'h03c, 4, 1'b1);
		chk(m.rq.size(), 4);
		for (i = 0; i < 4; i++)
			chk(m.rq[i], {4'h3, exp[i], RESP_OKAY, i == 3});
	endtask

	// Write and read run at once on separate channels, then the write is read back.
	task t_overlap;
		fork
			m.wr(4'h1, 12'h00c, 32'h0bad_cafe, 2, 0);
			m.rd(4'h2, 12'h03c, 1, 1'b0);
		join
		chk(m.b_got, {4'h1, RESP_OKAY});
		chk(m.rq[0], {4'h2, 32'ha5a5_0000, RESP_OKAY, 1'b1});
		m.rd(4'h7, 12'h00c, 2, 1'b0);
		chk(m.rq[0], {4'h7, 32'h0bad_cafe, RESP_OKAY, 1'b0});
		chk(m.rq[1], {4'h7, 32'h0bad_caff, RESP_OKAY, 1'b1});
	endtask

	// Clock generator.
	always #25 ref_clk = ~ref_clk;

	// Main sequence.
	initial
	begin
		ref_clk = 1'b0;
		rst = 1'b1;
		repeat (12) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_writes();
		t_read_burst();
		t_overlap();
		print_verdict();
	end

	// Watchdog against a hung handshake.
	initial
	begin
		#100000;
		err_count++;
		print_verdict();
	end
endmodule
